// ### qpfe_pkg.sv
// Package for the quad-phase fetch/execute sequencer: widths, phases and carriers.
package qpfe_pkg;

   // ----------------------------------------------------------------------
   // Sizes and constants
   // ----------------------------------------------------------------------
   localparam int             QPFE_PC_W        = 12;
   localparam int             QPFE_IMPL_W      = 10;
   localparam int             QPFE_INSTR_W     = 12;
   localparam int             QPFE_DATA_W      = 8;
   localparam int             QPFE_DADDR_W     = 7;
   localparam int             QPFE_PHASES      = 4;
   localparam logic [11:0]    QPFE_RESET_PC    = 12'h000;
   localparam logic [11:0]    QPFE_IMPL_MASK   = 12'h3ff;
   localparam logic [11:0]    QPFE_NOP         = 12'h000;
   localparam logic [7:0]     QPFE_STATUS_RESET = 8'h18;
   localparam logic [7:0]     QPFE_PTR_RESET   = 8'hc0;
   localparam int             QPFE_PAGE_BIT    = 5;
   localparam int             QPFE_BANK_LSB    = 5;
   localparam logic [4:0]     QPFE_PTR_ADDR    = 5'h04;
   localparam logic [4:0]     QPFE_STATUS_ADDR = 5'h03;
   localparam logic [4:0]     QPFE_PCL_ADDR    = 5'h02;
   localparam logic [4:0]     QPFE_BANKED_MIN  = 5'h10;

   // ----------------------------------------------------------------------
   // Phase encoding
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      phase_first,
      phase_second,
      phase_third,
      phase_fourth
   } qpfe_phase_e;

   // Data memory request toward the register file.
   typedef struct packed {
      logic                    rd;
      logic                    wr;
      logic [6:0]              addr;
      logic [7:0]              wdata;
   } qpfe_dmem_s;

endpackage : qpfe_pkg

// ### qpfe_seq.sv
// Quad-phase fetch/execute sequencer with paging, banking and branch flush.
`timescale 1ns/1ns
module qpfe_seq
   import qpfe_pkg::*;
(
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   // Program memory
   output logic [QPFE_IMPL_W-1:0]      pmem_addr,
   input  wire logic [QPFE_INSTR_W-1:0] pmem_rdata,
   // Data memory
   output qpfe_dmem_s                  dmem_req,
   input  wire logic [QPFE_DATA_W-1:0] dmem_rdata,
   // Phase and status view
   output qpfe_phase_e                 phase,
   output logic [QPFE_INSTR_W-1:0]     instr_hold_reg,
   output logic                        instr_valid,
   output logic [QPFE_PC_W-1:0]        pc,
   output logic [QPFE_DATA_W-1:0]      status_reg,
   output logic [QPFE_DATA_W-1:0]      indirect_addr_pointer,
   output logic [QPFE_DATA_W-1:0]      work_reg
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   qpfe_phase_e                 next_phase;
   logic [QPFE_PC_W-1:0]        next_pc;
   logic [QPFE_INSTR_W-1:0]     next_instr_hold_reg;
   logic                        next_instr_valid;
   logic [QPFE_IMPL_W-1:0]      next_pmem_addr;
   qpfe_dmem_s                  next_dmem_req;
   logic [QPFE_DATA_W-1:0]      operand;
   logic [QPFE_DATA_W-1:0]      next_operand;
   logic [QPFE_DATA_W-1:0]      next_status_reg;
   logic [QPFE_DATA_W-1:0]      next_indirect_addr_pointer;
   logic [QPFE_DATA_W-1:0]      next_work_reg;

   // ----------------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------------
   // Decoded subset: 101t_tttt_tttt jumps, 0000_001f_ffff moves the working
   // value to a file, 0010_000f_ffff moves a file to the working value and
   // 1100_kkkk_kkkk loads a literal. Everything else executes as a no-op,
   // which keeps the sequencing complete without a full instruction set.
   function automatic logic is_jump(input logic [11:0] ins);
      return ins[11:9] == 3'b101;
   endfunction : is_jump

   function automatic logic is_move_to_file(input logic [11:0] ins);
      return ins[11:5] == 7'b0000001;
   endfunction : is_move_to_file

   // Jump targets carry nine bits; the page bit of the status value fills the
   // tenth, and the upper bits stay clear so the target lies in the 1K space.
   function automatic logic [QPFE_PC_W-1:0] jump_target(input logic [11:0] ins, input logic [7:0] stat);
      logic [QPFE_PC_W-1:0] tgt;
      tgt                = '0;
      tgt[8:0]           = ins[8:0];
      tgt[QPFE_IMPL_W-1] = stat[QPFE_PAGE_BIT];
      return tgt;
   endfunction : jump_target

   // Files at and above the banked floor take two bank bits from the pointer;
   // below it every bank sees the same registers.
   function automatic logic [6:0] data_addr(input logic [4:0] f, input logic [7:0] ptr);
      logic [4:0] eff;
      eff = (f == 5'h00) ? ptr[4:0] : f;
      if (eff >= QPFE_BANKED_MIN) begin
         return {ptr[QPFE_BANK_LSB+1:QPFE_BANK_LSB], eff};
      end
      return {2'b00, eff};
   endfunction : data_addr

   // ----------------------------------------------------------------------
   // Phase counter
   // ----------------------------------------------------------------------
   // The phase free-runs from reset; every other stage keys off it, so no
   // stage needs a divider of its own.
   always_comb begin
      next_phase = qpfe_phase_e'(phase + 2'd1);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= phase_first;
      end else begin
         phase <= next_phase;
      end
   end

   // ----------------------------------------------------------------------
   // Fetch stage: program counter, fetch address and instruction hold
   // ----------------------------------------------------------------------
   // Outputs are registered, so each action shows one edge after the phase
   // that asks for it: the fetch address stands from the second phase on.
   // A jump or a write to the low program counter byte voids the word that
   // was fetched alongside it by clearing the valid flag, which turns it into
   // a bubble without a separate flush register.
   always_comb begin
      next_pc             = pc;
      next_pmem_addr      = pmem_addr;
      next_instr_hold_reg = instr_hold_reg;
      next_instr_valid    = instr_valid;
      case (phase)
         phase_first: begin
            next_pc        = pc + 12'd1;
            next_pmem_addr = pc[QPFE_IMPL_W-1:0];
         end
         phase_fourth: begin
            next_instr_hold_reg = pmem_rdata;
            next_instr_valid    = 1'b1;
            if (instr_valid && is_jump(instr_hold_reg)) begin
               next_pc          = jump_target(instr_hold_reg, status_reg);
               next_instr_valid = 1'b0;
            end else if (instr_valid && is_move_to_file(instr_hold_reg) &&
                         instr_hold_reg[4:0] == QPFE_PCL_ADDR) begin
               next_pc          = {pc[QPFE_PC_W-1:8], work_reg};
               next_instr_valid = 1'b0;
            end
         end
         default: begin
            next_pc = pc;
         end
      endcase
   end

   // Reset leaves the hold register empty so nothing executes before a fetch.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pc             <= QPFE_RESET_PC;
         pmem_addr      <= '0;
         instr_hold_reg <= QPFE_NOP;
         instr_valid    <= 1'b0;
      end else begin
         pc             <= next_pc;
         pmem_addr      <= next_pmem_addr;
         instr_hold_reg <= next_instr_hold_reg;
         instr_valid    <= next_instr_valid;
      end
   end

   // ----------------------------------------------------------------------
   // Execute stage: data memory slots, working value and pointers
   // ----------------------------------------------------------------------
   // The read strobe stands in the third phase and the operand is taken at
   // its end, which needs a memory that answers in the same cycle. The write
   // strobe stands in the first phase of the next cycle, so it lands before
   // the following instruction reads.
   always_comb begin
      next_dmem_req              = dmem_req;
      next_dmem_req.rd           = 1'b0;
      next_dmem_req.wr           = 1'b0;
      next_operand               = operand;
      next_status_reg            = status_reg;
      next_indirect_addr_pointer = indirect_addr_pointer;
      next_work_reg              = work_reg;
      case (phase)
         phase_second: begin
            if (instr_valid && !is_jump(instr_hold_reg)) begin
               next_dmem_req.rd   = 1'b1;
               next_dmem_req.addr = data_addr(instr_hold_reg[4:0], indirect_addr_pointer);
            end
         end
         phase_third: begin
            next_operand = dmem_rdata;
         end
         phase_fourth: begin
            if (instr_valid && is_move_to_file(instr_hold_reg)) begin
               // Move working value to file: issued in the fourth phase, strobed in the next first phase.
               next_dmem_req.wr    = 1'b1;
               next_dmem_req.addr  = data_addr(instr_hold_reg[4:0], indirect_addr_pointer);
               next_dmem_req.wdata = work_reg;
               if (instr_hold_reg[4:0] == QPFE_PTR_ADDR) begin
                  next_indirect_addr_pointer = work_reg;
               end else if (instr_hold_reg[4:0] == QPFE_STATUS_ADDR) begin
                  next_status_reg = work_reg;
               end
            end else if (instr_valid && instr_hold_reg[11:5] == 7'b0010000) begin
               // Move file to working value.
               next_work_reg = operand;
            end else if (instr_valid && instr_hold_reg[11:8] == 4'b1100) begin
               next_work_reg = instr_hold_reg[7:0];
            end
         end
         default: begin
            next_operand = operand;
         end
      endcase
   end

   // Reset puts the program page at zero and the pointer in an upper bank.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dmem_req              <= '0;
         operand               <= '0;
         status_reg            <= QPFE_STATUS_RESET;
         indirect_addr_pointer <= QPFE_PTR_RESET;
         work_reg              <= '0;
      end else begin
         dmem_req              <= next_dmem_req;
         operand               <= next_operand;
         status_reg            <= next_status_reg;
         indirect_addr_pointer <= next_indirect_addr_pointer;
         work_reg              <= next_work_reg;
      end
   end

endmodule : qpfe_seq

// ### qpfe_seq_checker.sv
// Checker for phase timing, fetch, execute slots and branch flush.
`timescale 1ns/1ns
module qpfe_seq_checker
   import qpfe_pkg::*;
(
   // Clock, reset and watched ports
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [9:0]  pmem_addr,
   input wire logic [11:0] pmem_rdata,
   input wire qpfe_dmem_s  dmem_req,
   input wire qpfe_phase_e phase,
   input wire logic [11:0] instr_hold_reg,
   input wire logic        instr_valid,
   input wire logic [11:0] pc,
   input wire logic [7:0]  status_reg
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_jump;
      instr_valid && instr_hold_reg[11:9] == 3'h5 && phase == phase_fourth;
   endsequence
   sequence s_flush;
      (!instr_valid) [*4] ##1 instr_valid;
   endsequence
   a_phase_step: assert property ($past(rst_n) |-> 2'(phase - $past(phase)) == 2'h1)
      else $error("phase did not step by one");
   a_pc_step: assert property (phase == phase_first |=> pc == $past(pc) + 12'h1)
      else $error("pc not incremented in first phase");
   a_pc_hold: assert property (phase inside {phase_second, phase_third} |=> $stable(pc))
      else $error("pc moved mid cycle");
   a_fetch_addr: assert property (phase == phase_second |-> pmem_addr == 10'(pc - 12'h1))
      else $error("fetch address wrong");
   a_ir_load: assert property (phase == phase_fourth |=> instr_hold_reg == $past(pmem_rdata))
      else $error("fetched word not latched");
   a_ir_hold: assert property (phase != phase_fourth |=> $stable(instr_hold_reg))
      else $error("instruction changed mid cycle");
   a_read_slot: assert property (dmem_req.rd |-> phase == phase_third && instr_valid ##1 !dmem_req.rd)
      else $error("read outside its slot");
   a_write_slot: assert property (dmem_req.wr |-> $past(phase) == phase_fourth && $past(instr_valid))
      else $error("write outside its slot");
   a_jump_flush: assert property (s_jump |=> s_flush)
      else $error("jump did not flush prefetch");
   a_jump_target: assert property (s_jump |=> pc[9:0] == {$past(status_reg[5]), $past(instr_hold_reg[8:0])})
      else $error("jump target or page wrong");
endmodule : qpfe_seq_checker
bind qpfe_seq qpfe_seq_checker chk (.mclk, .rst_n, .pmem_addr, .pmem_rdata, .dmem_req, .phase,
   .instr_hold_reg, .instr_valid, .pc, .status_reg);

// ### qpfe_mem_model.sv
// Program memory and register file model facing the sequencer.
`timescale 1ns/1ns
module qpfe_mem_model
   import qpfe_pkg::*;
(
   // Clock
   input  wire logic        mclk,
   // Memory sides
   input  wire logic [9:0]  pmem_addr,
   output logic [11:0]      pmem_rdata,
   input  wire qpfe_dmem_s  dmem_req,
   output logic [7:0]       dmem_rdata
);
   logic [11:0] prog [1024];
   logic [7:0]  regs [128];
   assign pmem_rdata = prog[pmem_addr];
   // Outside the read slot the bus shows the inverse, so a stale sample is caught.
   assign dmem_rdata = dmem_req.rd ? regs[dmem_req.addr] : ~regs[dmem_req.addr];
   always @(posedge mclk) begin
      if (dmem_req.wr) begin
         regs[dmem_req.addr] <= dmem_req.wdata;
      end
   end
endmodule : qpfe_mem_model

// ### tb_top.sv
// Testbench running a short program through the sequencer.
`timescale 1ns/1ns
module tb_top;
   import qpfe_pkg::*;
   logic        mclk, rst_n, instr_valid;
   logic [9:0]  pmem_addr;
   logic [11:0] pmem_rdata, instr_hold_reg, pc;
   logic [7:0]  dmem_rdata, status_reg, ptr, work_reg;
   qpfe_dmem_s  dmem_req;
   qpfe_phase_e phase;
   int          fails, n_tests;
   // Jump at 5 flushes 6, jump at 11 sets page and flushes 12.
   localparam logic [11:0] PROG [13] = '{12'hc5a, 12'h030, 12'hc00, 12'h210, 12'h032, 12'ha09,
      12'h031, 12'h000, 12'h000, 12'hc20, 12'h023, 12'ha05, 12'h031};
   // Page one at 0x205: pointer write, indirect banked write, then a jump by writing the
   // low program counter byte, which voids 0x031 at 0x20b and skips 0xc55 at 0x20c.
   localparam logic [11:0] PAGE1 [8] = '{12'hc31, 12'h024, 12'hc77, 12'h020, 12'hc10, 12'h022,
      12'h031, 12'hc55};
   qpfe_seq dut (.mclk(mclk), .rst_n(rst_n), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
      .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .phase(phase), .instr_hold_reg(instr_hold_reg),
      .instr_valid(instr_valid), .pc(pc), .status_reg(status_reg), .indirect_addr_pointer(ptr),
      .work_reg(work_reg));
   qpfe_mem_model mem (.mclk(mclk), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
      .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic end_of_test;
      if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   task automatic wait_pc(input logic [11:0] v, input int lim);
      for (int i = 0; i < lim && pc !== v; i++) @(negedge mclk);
      if (pc !== v) begin
         fails++;
         end_of_test();
      end
   endtask : wait_pc
   task automatic t_reset;
      repeat (8) @(negedge mclk);
      chk("pc", pc, 12'h000);
      chk("fetch addr", {2'h0, pmem_addr}, 12'h000);
      chk("valid", {11'h0, instr_valid}, 12'h000);
      chk("write", {11'h0, dmem_req.wr}, 12'h000);
      chk("status", {4'h0, status_reg}, {4'h0, QPFE_STATUS_RESET});
      chk("pointer", {4'h0, ptr}, {4'h0, QPFE_PTR_RESET});
      rst_n = 1'b1;
   endtask : t_reset
   task automatic t_program;
      wait_pc(12'h206, 300);
      chk("banked write", {4'h0, mem.regs[7'h50]}, 12'h05a);
      chk("operand read", {4'h0, mem.regs[7'h52]}, 12'h05a);
      chk("flushed write", {4'h0, mem.regs[7'h51]}, 12'h000);
      chk("page bit", {11'h0, status_reg[5]}, 12'h001);
      chk("work", {4'h0, work_reg}, 12'h020);
   endtask : t_program
   task automatic t_indirect;
      wait_pc(12'h211, 200);
      chk("pointer write", {4'h0, ptr}, 12'h031);
      chk("indirect write", {4'h0, mem.regs[7'h31]}, 12'h077);
      chk("pc write work", {4'h0, work_reg}, 12'h010);
   endtask : t_indirect
   task automatic t_wrap;
      wait_pc(12'h401, 6000);
      chk("wrapped addr", {2'h0, pmem_addr}, 12'h000);
      repeat (3) @(negedge mclk);
      chk("wrapped word", instr_hold_reg, PROG[0]);
   endtask : t_wrap
   initial begin
      rst_n = 1'b0;
      fails = 0;
      n_tests = 0;
      foreach (mem.prog[i]) begin
         if (i < 13) mem.prog[i] = PROG[i];
         else if (i >= 32'h205 && i < 32'h20d) mem.prog[i] = PAGE1[i - 32'h205];
         else mem.prog[i] = 12'h000;
      end
      foreach (mem.regs[i]) mem.regs[i] = 8'h00;
      t_reset();
      t_program();
      t_indirect();
      t_wrap();
      end_of_test();
   end
endmodule : tb_top
